// ---- rtl/ext_display_ctrl.sv ----
// Extended display control register bank behind the indexed data port
//
// Function
// [R1] Each register is one byte, reached by index through the data port.
// [R2] Horizontal overflow supplies bit 8 and bit 6 high bits of timing.
// [R3] Vertical overflow supplies bit 10 of five vertical timing values.
// [R4] Image write swap: none, bytes in word, or full doubleword reversal.
// [R5] Palette memory access allowed when its bit is 1; resets to 1.
// [R6] Firmware should clear the palette access enable after reset.
// [R7] Blanking output delayed zero to seven dot clocks by a field.
// [R8] Enhanced bit off allows legacy modes only; on enables engine.
// [R9] Writing 1 to engine reset resets engine and memory control.
// [R10] Both disconnect bits set: disconnect on full fifo write or busy read.
// [R11] Master disconnect: break burst on misaligned or out-of-range address.
// [R12] Pixel address tri-state bit floats all sixteen address outputs.
// [R13] Video clock in phase with dot clock at 1, inverted at 0.
// [R14] Overlay mode: off, secondary over legacy, or full; 10 reserved.
// [R15] Software should switch overlay only during vertical sync.
// [R16] Colour mode field selects one of five modes, others reserved.
// [R17] Reset samples eight strap pins into the strapped register.
// [R18] Strapped register locked until unlock value is in the lock register.
// [R19] Column strobe adjust step, 11 none; timing bit selects shift style; the code ties col_strobe_whole to 0.
// [R20] Row strobe low time 4.5 or 3.5 memory clocks.
// [R21] Row strobe precharge 3.5 or 2.5 memory clocks.
// [R22] Display start high bits override older bits when non-zero.
// [R23] CPU page bits override older bits when non-zero and banking is on.
// [R24] Linear 64K window shows the page selected by the CPU page field; the code does so only while BANKING_CONTROL is 1.
`timescale 1ns/1ps
`default_nettype none
`include "ext_display_ctrl_defs.svh"

module ext_display_ctrl #(
    parameter int BLANK_DELAY_MAX = 7
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // Indexed data port
    input wire ext_display_ctrl_pkg::port_access_t PORT_IN,
    output logic [7:0] PORT_RDATA,
    // Strap pins and lock
    input wire logic [7:0] STRAP_PINS_THIRD_BYTE,
    input wire logic [7:0] REGISTER_LOCK,
    // Low timing bits, older address bits and controls from the base registers
    input wire logic [7:0] HORIZ_LOW [7],
    input wire logic [7:0] VERT_LOW [5],
    input wire logic [15:0] OLD_DISPLAY_START,
    input wire logic [5:0] OLD_CPU_BASE,
    input wire logic BANKING_CONTROL,
    input wire logic LINEAR_EN,
    input wire logic WINDOW_64K,
    // Dot clock side
    input wire logic DOT_CLOCK,
    input wire logic BLANK_IN_B,
    output logic BLANK_OUT_B,
    output logic VIDEO_OUT_CLOCK,
    input wire logic [15:0] PIXEL_ADDRESS_IN,
    output logic [15:0] PIXEL_ADDRESS_BUS,
    output logic PIXEL_ADDRESS_OE,
    // Bus disconnect
    input wire logic BUS_WRITE,
    input wire logic BUS_READ,
    input wire logic CMD_FIFO_FULL,
    input wire logic CMD_FIFO_EMPTY,
    input wire logic LOCAL_PORT_FIFO_FULL,
    input wire logic BURST_ACTIVE,
    input wire logic [1:0] BURST_ADDR_LOW,
    input wire logic BURST_IN_RANGE,
    output logic BUS_DISCONNECT,
    // Decoded controls
    output logic [7:0] GENERAL_OUT,
    output ext_display_ctrl_pkg::horiz_timing_t HORIZ_TIMING,
    output ext_display_ctrl_pkg::vert_timing_t VERT_TIMING,
    output logic [1:0] IMAGE_SWAP_MODE,
    output logic PALETTE_MEM_ACCESS_EN,
    output logic ENHANCED_FUNCTION_EN,
    output logic ENGINE_RESET,
    output ext_display_ctrl_pkg::overlay_mode_t OVERLAY_MODE,
    output ext_display_ctrl_pkg::colour_mode_t COLOUR_MODE,
    output ext_display_ctrl_pkg::mem_timing_t MEM_TIMING,
    output logic [19:0] DISPLAY_START_HIGH_SEL,
    output logic [5:0] CPU_PAGE
);

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    // ==========================================================
    // Register storage
    logic [7:0] gen_out_reg;
    logic [7:0] horiz_reg;
    logic [7:0] vert_reg;
    logic [7:0] swap_reg;
    logic [7:0] blank_reg;
    logic [7:0] engine_reg;
    logic [7:0] overlay_reg;
    logic [7:0] strap_reg;
    logic [7:0] dstart_reg;
    logic [7:0] cpage_reg;
    logic [7:0] flag_three_reg;
    logic strap_taken_reg;
    logic engine_reset_reg;

    wire unlocked = (REGISTER_LOCK == `UNLOCK_VALUE);
    wire wr = PORT_IN.write;
    wire [7:0] idx = PORT_IN.index;
    wire [7:0] wd = PORT_IN.wdata;
    wire strap_ok = unlocked; // [R18]

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            gen_out_reg <= `RST_ZERO;
            horiz_reg <= `RST_ZERO;
            vert_reg <= `RST_ZERO;
            swap_reg <= `RST_ZERO;
            blank_reg <= `RST_BLANK_DELAY; // [R5]
            engine_reg <= `RST_ZERO;
            overlay_reg <= `RST_ZERO;
            dstart_reg <= `RST_ZERO;
            cpage_reg <= `RST_ZERO;
            flag_three_reg <= `RST_ZERO;
        end else if (wr) begin // [R1]
            unique case (idx)
                `IDX_GENERAL_OUTPUT_PORT: gen_out_reg <= wd;
                `IDX_HORIZ_OVERFLOW: horiz_reg <= wd & `MASK_HORIZ;
                `IDX_VERT_OVERFLOW: vert_reg <= wd & `MASK_VERT;
                `IDX_IMAGE_SWAP: swap_reg <= wd & `MASK_SWAP;
                `IDX_BLANK_DELAY: blank_reg <= wd & `MASK_BLANK;
                `IDX_ENGINE_BUS: engine_reg <= wd & `MASK_ENGINE;
                `IDX_OVERLAY_COLOUR: overlay_reg <= wd & `MASK_OVERLAY;
                `IDX_DISPLAY_START_HIGH: dstart_reg <= wd & `MASK_DSTART;
                `IDX_CPU_PAGE_HIGH: cpage_reg <= wd & `MASK_CPAGE;
                `IDX_FIRMWARE_FLAG_THREE: flag_three_reg <= wd;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Strap capture after reset release, locked writes afterwards
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            strap_taken_reg <= 1'b0;
            strap_reg <= `RST_ZERO;
        end else if (!strap_taken_reg) begin
            strap_taken_reg <= 1'b1;
            strap_reg <= STRAP_PINS_THIRD_BYTE; // [R17]
        end else if (wr && idx == `IDX_STRAP_TIMING && strap_ok) begin
            strap_reg <= wd; // [R18]
        end
    end

    // Engine reset is a one-cycle pulse; the bit itself never stores
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            engine_reset_reg <= 1'b0;
        end else begin
            engine_reset_reg <= wr && idx == `IDX_ENGINE_BUS
                && wd[`BIT_ENGINE_RST]; // [R9]
        end
    end
    assign ENGINE_RESET = engine_reset_reg;

    // ==========================================================
    // Read back
    logic [7:0] rdata;
    always_comb begin
        unique case (idx)
            `IDX_GENERAL_OUTPUT_PORT: rdata = gen_out_reg;
            `IDX_HORIZ_OVERFLOW: rdata = horiz_reg;
            `IDX_VERT_OVERFLOW: rdata = vert_reg;
            `IDX_IMAGE_SWAP: rdata = swap_reg;
            `IDX_BLANK_DELAY: rdata = blank_reg;
            `IDX_ENGINE_BUS: rdata = engine_reg;
            `IDX_OVERLAY_COLOUR: rdata = overlay_reg;
            `IDX_STRAP_TIMING: rdata = strap_ok ? strap_reg : 8'h00; // [R18]
            `IDX_DISPLAY_START_HIGH: rdata = dstart_reg;
            `IDX_CPU_PAGE_HIGH: rdata = cpage_reg;
            `IDX_FIRMWARE_FLAG_THREE: rdata = flag_three_reg;
            default: rdata = 8'h00;
        endcase
    end
    assign PORT_RDATA = rdata; // [R1]
    assign GENERAL_OUT = gen_out_reg;

    // ==========================================================
    // Timing overflow bits
    assign HORIZ_TIMING.horiz_total = {horiz_reg[0], HORIZ_LOW[0]}; // [R2]
    assign HORIZ_TIMING.horiz_display_end = {horiz_reg[1], HORIZ_LOW[1]};
    assign HORIZ_TIMING.horiz_blank_start = {horiz_reg[2], HORIZ_LOW[2]};
    assign HORIZ_TIMING.horiz_blank_end = {horiz_reg[3], HORIZ_LOW[3][5:0]};
    assign HORIZ_TIMING.horiz_sync_start = {horiz_reg[4], HORIZ_LOW[4]};
    assign HORIZ_TIMING.horiz_sync_end = {horiz_reg[5], HORIZ_LOW[5][5:0]};
    assign HORIZ_TIMING.fifo_fetch_start = {horiz_reg[6], HORIZ_LOW[6]};
    assign VERT_TIMING.vert_total = {vert_reg[0], 2'b00, VERT_LOW[0]}; // [R3]
    assign VERT_TIMING.vert_display_end = {vert_reg[1], 2'b00, VERT_LOW[1]};
    assign VERT_TIMING.vert_blank_start = {vert_reg[2], 2'b00, VERT_LOW[2]};
    assign VERT_TIMING.vert_retrace_start = {vert_reg[4], 2'b00, VERT_LOW[3]};
    assign VERT_TIMING.line_compare = {vert_reg[6], 2'b00, VERT_LOW[4]};

    // ==========================================================
    // Control fields
    assign IMAGE_SWAP_MODE = swap_reg[6:5]; // [R4]
    assign PALETTE_MEM_ACCESS_EN = blank_reg[`BIT_PAL_ACCESS]; // [R5]
    assign ENHANCED_FUNCTION_EN = engine_reg[`BIT_ENH_EN]; // [R8]
    assign OVERLAY_MODE =
        ext_display_ctrl_pkg::overlay_mode_t'(overlay_reg[3:2]); // [R14]

    always_comb begin
        unique case (overlay_reg[7:4]) // [R16]
            4'h0: COLOUR_MODE = ext_display_ctrl_pkg::COLOUR_8BIT_ONE;
            4'h1: COLOUR_MODE = ext_display_ctrl_pkg::COLOUR_8BIT_TWO;
            4'h3: COLOUR_MODE = ext_display_ctrl_pkg::COLOUR_15BIT;
            4'h5: COLOUR_MODE = ext_display_ctrl_pkg::COLOUR_16BIT;
            4'hD: COLOUR_MODE = ext_display_ctrl_pkg::COLOUR_24BIT;
            default: COLOUR_MODE = ext_display_ctrl_pkg::COLOUR_RESERVED;
        endcase
    end

    // Memory timings in half memory clocks
    assign MEM_TIMING.row_low_half = strap_reg[`BIT_ROW_LOW] ?
        `ROW_LOW_SHORT_HALF : `ROW_LOW_LONG_HALF; // [R20]
    assign MEM_TIMING.row_pcg_half = strap_reg[`BIT_ROW_PCG] ?
        `ROW_PCG_SHORT_HALF : `ROW_PCG_LONG_HALF; // [R21]
    assign MEM_TIMING.col_strobe_adjust = strap_reg[1:0]; // [R19]
    assign MEM_TIMING.col_strobe_whole = 1'b0;

    // Address high bits with override of older bits
    wire dstart_new = (dstart_reg[3:0] != 4'h0);
    assign DISPLAY_START_HIGH_SEL = dstart_new ?
        {dstart_reg[3:0], OLD_DISPLAY_START} :
        {4'h0, OLD_DISPLAY_START}; // [R22]
    wire cpage_new = BANKING_CONTROL && ((cpage_reg[5:0] != 6'h00) ||
        (LINEAR_EN && WINDOW_64K)); // [R23] [R24]
    assign CPU_PAGE = cpage_new ? cpage_reg[5:0] : OLD_CPU_BASE; // [R24]

    // ==========================================================
    // Blank delay on the dot clock side, sampled as a plain input
    logic [BLANK_DELAY_MAX-1:0] blank_pipe_reg;
    logic dot_prev_reg;
    wire dot_rise = DOT_CLOCK && !dot_prev_reg;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            dot_prev_reg <= 1'b0;
            blank_pipe_reg <= '1;
        end else begin
            dot_prev_reg <= DOT_CLOCK;
            if (dot_rise)
                blank_pipe_reg <=
                    {blank_pipe_reg[BLANK_DELAY_MAX-2:0], BLANK_IN_B};
        end
    end
    wire [2:0] bdly = blank_reg[5:3];
    assign BLANK_OUT_B = (bdly == 3'd0) ? BLANK_IN_B
        : blank_pipe_reg[bdly - 3'd1]; // [R7]

    assign VIDEO_OUT_CLOCK = overlay_reg[`BIT_CLK_PHASE] ?
        DOT_CLOCK : ~DOT_CLOCK; // [R13]

    assign PIXEL_ADDRESS_BUS = PIXEL_ADDRESS_IN;
    assign PIXEL_ADDRESS_OE = ~engine_reg[`BIT_PA_TRISTATE]; // [R12]

    // ==========================================================
    // Bus disconnect
    wire master_disc = engine_reg[`BIT_MASTER_DISC];
    wire fifo_disc = engine_reg[`BIT_FIFO_DISC] && master_disc &&
        ((BUS_WRITE && (CMD_FIFO_FULL || LOCAL_PORT_FIFO_FULL)) ||
         (BUS_READ && !CMD_FIFO_EMPTY)); // [R10]
    wire burst_disc = master_disc && BURST_ACTIVE &&
        (BURST_ADDR_LOW != 2'b00 || !BURST_IN_RANGE); // [R11]
    assign BUS_DISCONNECT = fifo_disc || burst_disc;

    // ==========================================================
    // Checks
    a_engine_reset_pulse: assert property ( // [R9]
        ENGINE_RESET |=> !ENGINE_RESET || $past(wr))
        else $error("engine reset held without write");
    a_strap_capture: assert property ( // [R17]
        !strap_taken_reg |=> strap_reg == $past(STRAP_PINS_THIRD_BYTE))
        else $error("strap pins not captured");
    a_strap_locked: assert property ( // [R18]
        strap_taken_reg && $past(strap_taken_reg) && !$past(strap_ok)
        |-> $stable(strap_reg))
        else $error("strapped register changed while locked");
    a_strap_read_zero: assert property ( // [R18]
        idx == `IDX_STRAP_TIMING && !strap_ok |-> PORT_RDATA == 8'h00)
        else $error("strapped register readable while locked");
    a_disc_needs_master: assert property ( // [R10]
        BUS_DISCONNECT |-> master_disc)
        else $error("disconnect without master enable");
    a_fifo_read_disc: assert property ( // [R10]
        engine_reg[`BIT_FIFO_DISC] && master_disc && BUS_READ &&
        !CMD_FIFO_EMPTY |-> BUS_DISCONNECT)
        else $error("busy fifo read not disconnected");
    a_burst_break: assert property ( // [R11]
        master_disc && BURST_ACTIVE && BURST_ADDR_LOW != 2'b00
        |-> BUS_DISCONNECT)
        else $error("misaligned burst not interrupted");
    a_tristate_oe: assert property ( // [R12]
        engine_reg[`BIT_PA_TRISTATE] |-> !PIXEL_ADDRESS_OE)
        else $error("pixel address driven while tri-stated");
    a_pixel_drive: assert property ( // [R12]
        !engine_reg[`BIT_PA_TRISTATE] |-> PIXEL_ADDRESS_OE)
        else $error("pixel address floated while enabled");
    a_swap_write: assert property ( // [R4]
        wr && idx == `IDX_IMAGE_SWAP |=> IMAGE_SWAP_MODE == $past(wd[6:5]))
        else $error("swap field not updated");
    a_palette_write: assert property ( // [R5]
        wr && idx == `IDX_BLANK_DELAY |=>
        PALETTE_MEM_ACCESS_EN == $past(wd[`BIT_PAL_ACCESS]))
        else $error("palette access bit not updated");
    a_enh_write: assert property ( // [R8]
        wr && idx == `IDX_ENGINE_BUS |=> ENHANCED_FUNCTION_EN == $past(wd[0]))
        else $error("enhanced bit not updated");
    a_overlay_write: assert property ( // [R14]
        wr && idx == `IDX_OVERLAY_COLOUR |=> OVERLAY_MODE == $past(wd[3:2]))
        else $error("overlay mode not updated");
    a_colour_reserved: assert property ( // [R16]
        wr && idx == `IDX_OVERLAY_COLOUR && wd[7:4] == 4'h2 |=>
        COLOUR_MODE == ext_display_ctrl_pkg::COLOUR_RESERVED)
        else $error("reserved colour code decoded as a mode");
    a_cpage_bank: assert property ( // [R23]
        !BANKING_CONTROL |-> CPU_PAGE == OLD_CPU_BASE)
        else $error("cpu page active without banking");
    a_cpage_linear: assert property ( // [R24]
        BANKING_CONTROL && LINEAR_EN && WINDOW_64K |->
        CPU_PAGE == cpage_reg[5:0])
        else $error("linear window page not from cpu page field");
    a_dstart_write: assert property ( // [R22]
        wr && idx == `IDX_DISPLAY_START_HIGH |=>
        DISPLAY_START_HIGH_SEL[19:16] == $past(wd[3:0]))
        else $error("display start high bits wrong");
    a_horiz_high: assert property ( // [R2]
        wr && idx == `IDX_HORIZ_OVERFLOW |=>
        HORIZ_TIMING.horiz_total[8] == $past(wd[0]))
        else $error("horizontal total bit 8 wrong");
    a_vert_high: assert property ( // [R3]
        wr && idx == `IDX_VERT_OVERFLOW |=>
        VERT_TIMING.line_compare[10] == $past(wd[6]))
        else $error("line compare bit 10 wrong");

endmodule : ext_display_ctrl
`default_nettype wire

// ---- rtl/ext_display_ctrl_defs.svh ----
// Offsets, field positions, reset values and timing constants of the bank
`ifndef EXT_DISPLAY_CTRL_DEFS_SVH
`define EXT_DISPLAY_CTRL_DEFS_SVH

`define IDX_GENERAL_OUTPUT_PORT 8'h5C
`define IDX_HORIZ_OVERFLOW 8'h5D
`define IDX_VERT_OVERFLOW 8'h5E
`define IDX_IMAGE_SWAP 8'h61
`define IDX_BLANK_DELAY 8'h65
`define IDX_ENGINE_BUS 8'h66
`define IDX_OVERLAY_COLOUR 8'h67
`define IDX_STRAP_TIMING 8'h68
`define IDX_DISPLAY_START_HIGH 8'h69
`define IDX_CPU_PAGE_HIGH 8'h6A
`define IDX_FIRMWARE_FLAG_THREE 8'h6B
`define IDX_REGISTER_LOCK 8'h39

`define UNLOCK_VALUE 8'hA5

`define RST_BLANK_DELAY 8'h04
`define RST_ZERO 8'h00

`define MASK_HORIZ 8'h7F
`define MASK_VERT 8'h57
`define MASK_SWAP 8'h60
`define MASK_BLANK 8'h3C
`define MASK_ENGINE 8'hC9
`define MASK_OVERLAY 8'hFD
`define MASK_DSTART 8'h0F
`define MASK_CPAGE 8'h3F

`define BIT_PAL_ACCESS 2
`define BIT_ENH_EN 0
`define BIT_ENGINE_RST 1
`define BIT_FIFO_DISC 3
`define BIT_PA_TRISTATE 6
`define BIT_MASTER_DISC 7
`define BIT_CLK_PHASE 0
`define BIT_ROW_LOW 2
`define BIT_ROW_PCG 3
`define BIT_BANK_EN 0

`define SWAP_NONE 2'b00
`define SWAP_WORD 2'b01
`define SWAP_DWORD 2'b10

`define ROW_LOW_LONG_HALF 4'd9
`define ROW_LOW_SHORT_HALF 4'd7
`define ROW_PCG_LONG_HALF 4'd7
`define ROW_PCG_SHORT_HALF 4'd5

`endif

// ---- rtl/ext_display_ctrl_pkg.sv ----
// Types shared by the extended display control bank
package ext_display_ctrl_pkg;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] index;
        logic [7:0] wdata;
    } port_access_t;

    typedef struct packed {
        logic [8:0] horiz_total;
        logic [8:0] horiz_display_end;
        logic [8:0] horiz_blank_start;
        logic [6:0] horiz_blank_end;
        logic [8:0] horiz_sync_start;
        logic [6:0] horiz_sync_end;
        logic [8:0] fifo_fetch_start;
    } horiz_timing_t;

    typedef struct packed {
        logic [10:0] vert_total;
        logic [10:0] vert_display_end;
        logic [10:0] vert_blank_start;
        logic [10:0] vert_retrace_start;
        logic [10:0] line_compare;
    } vert_timing_t;

    typedef enum logic [1:0] {
        OVERLAY_OFF,
        OVERLAY_SECONDARY,
        OVERLAY_RESERVED,
        OVERLAY_FULL
    } overlay_mode_t;

    typedef enum logic [2:0] {
        COLOUR_8BIT_ONE,
        COLOUR_8BIT_TWO,
        COLOUR_15BIT,
        COLOUR_16BIT,
        COLOUR_24BIT,
        COLOUR_RESERVED
    } colour_mode_t;

    typedef struct packed {
        logic [3:0] row_low_half;
        logic [3:0] row_pcg_half;
        logic [1:0] col_strobe_adjust;
        logic       col_strobe_whole;
    } mem_timing_t;

endpackage : ext_display_ctrl_pkg

// ---- tb/ext_display_ctrl_tb.sv ----
// Self-checking bench for the extended display control register bank
`timescale 1ns/1ps
`default_nettype none
`include "ext_display_ctrl_defs.svh"

module ext_display_ctrl_tb;
    // ==========================================================
    // Signals
    logic clk, rst_b, banking, linear_en, win64, dot_clock, blank_in_b;
    logic blank_out_b, video_out_clock, pa_oe, bus_write, bus_read, cmd_full;
    logic cmd_empty, lp_full, burst, in_range, disc, pal_en, enh_en, eng_rst;
    ext_display_ctrl_pkg::port_access_t port_in;
    logic [7:0] port_rdata, strap, lock, general_out;
    logic [7:0] horiz_low [7];
    logic [7:0] vert_low [5];
    logic [15:0] old_start, pa_in, pa_bus;
    logic [5:0] old_cpu, cpu_page;
    logic [1:0] burst_low, swap;
    logic [19:0] dstart;
    ext_display_ctrl_pkg::horiz_timing_t ht;
    ext_display_ctrl_pkg::vert_timing_t vt;
    ext_display_ctrl_pkg::overlay_mode_t ovl;
    ext_display_ctrl_pkg::colour_mode_t col;
    ext_display_ctrl_pkg::mem_timing_t mt;
    int bad_count, n_compared;
    localparam logic [7:0] idx_tab [10] = '{8'h5C, 8'h5D, 8'h5E, 8'h61,
        8'h65, 8'h66, 8'h67, 8'h69, 8'h6A, 8'h6B};
    localparam logic [7:0] msk_tab [10] = '{8'hFF, 8'h7F, 8'h57, 8'h60,
        8'h3C, 8'hC9, 8'hFD, 8'h0F, 8'h3F, 8'hFF};
    localparam logic [3:0] col_code [6] = '{4'h0, 4'h1, 4'h3, 4'h5,
        4'hD, 4'h2};

    ext_display_ctrl uut (.CLK(clk), .RST_B(rst_b), .PORT_IN(port_in),
        .PORT_RDATA(port_rdata), .STRAP_PINS_THIRD_BYTE(strap),
        .REGISTER_LOCK(lock), .HORIZ_LOW(horiz_low), .VERT_LOW(vert_low),
        .OLD_DISPLAY_START(old_start), .OLD_CPU_BASE(old_cpu),
        .BANKING_CONTROL(banking), .LINEAR_EN(linear_en),
        .WINDOW_64K(win64), .DOT_CLOCK(dot_clock), .BLANK_IN_B(blank_in_b),
        .BLANK_OUT_B(blank_out_b), .VIDEO_OUT_CLOCK(video_out_clock),
        .PIXEL_ADDRESS_IN(pa_in), .PIXEL_ADDRESS_BUS(pa_bus),
        .PIXEL_ADDRESS_OE(pa_oe), .BUS_WRITE(bus_write),
        .BUS_READ(bus_read), .CMD_FIFO_FULL(cmd_full),
        .CMD_FIFO_EMPTY(cmd_empty), .LOCAL_PORT_FIFO_FULL(lp_full),
        .BURST_ACTIVE(burst), .BURST_ADDR_LOW(burst_low),
        .BURST_IN_RANGE(in_range), .BUS_DISCONNECT(disc),
        .GENERAL_OUT(general_out), .HORIZ_TIMING(ht), .VERT_TIMING(vt),
        .IMAGE_SWAP_MODE(swap), .PALETTE_MEM_ACCESS_EN(pal_en),
        .ENHANCED_FUNCTION_EN(enh_en), .ENGINE_RESET(eng_rst),
        .OVERLAY_MODE(ovl), .COLOUR_MODE(col), .MEM_TIMING(mt),
        .DISPLAY_START_HIGH_SEL(dstart), .CPU_PAGE(cpu_page));

    // ==========================================================
    // Port access and comparison
    task automatic chk(input string what, input logic [19:0] exp,
                       input logic [19:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(negedge clk);
        port_in = '{write: 1'b1, read: 1'b0, index: idx, wdata: d};
        @(negedge clk);
        port_in.write = 1'b0;
    endtask : wr

    task automatic rchk(input string what, input logic [7:0] idx,
                        input logic [7:0] exp);
        @(negedge clk);
        port_in.index = idx;
        port_in.read = 1'b1;
        #1;
        chk(what, {12'h000, exp}, {12'h000, port_rdata});
        @(negedge clk);
        port_in.read = 1'b0;
    endtask : rchk

    task automatic bus(input logic [7:0] v, input logic [1:0] lo,
                       input logic exp);
        @(negedge clk);
        {bus_write, bus_read, cmd_full, cmd_empty, lp_full} = v[4:0];
        {burst, in_range} = v[7:6];
        burst_low = lo;
        #1;
        chk("disconnect", {19'h0, exp}, {19'h0, disc});
    endtask : bus

    // ==========================================================
    // Scenarios
    task automatic t_reset_masks();
        for (int i = 0; i < 10; i++) begin
            rchk("reset", idx_tab[i],
                 idx_tab[i] == 8'h65 ? 8'h04 : 8'h00);
        end
        chk("palette_en", 20'h1, {19'h0, pal_en});
        for (int i = 0; i < 10; i++) begin
            wr(idx_tab[i], 8'hFF);
            rchk("mask", idx_tab[i], msk_tab[i]);
            wr(idx_tab[i], 8'h00);
        end
        wr(8'h5C, 8'h5A);
        chk("gen_out", 20'h5A, {12'h0, general_out});
        wr(8'h60, 8'hFF);
        rchk("unmapped", 8'h60, 8'h00);
        chk("palette_off", 20'h0, {19'h0, pal_en});
    endtask : t_reset_masks

    task automatic t_overflow();
        wr(8'h5D, 8'h7F);
        chk("h_total", 20'h100, ht.horiz_total);
        chk("h_blank_end", 20'h40, ht.horiz_blank_end);
        chk("h_sync_end", 20'h40, ht.horiz_sync_end);
        chk("h_fifo", 20'h100, ht.fifo_fetch_start);
        @(negedge clk);
        horiz_low[0] = 8'hAB;
        wr(8'h5D, 8'h10);
        chk("h_total_lo", 20'h0AB, ht.horiz_total);
        chk("h_sync_start", 20'h100, ht.horiz_sync_start);
        wr(8'h5E, 8'h57);
        chk("v_total", 20'h400, vt.vert_total);
        chk("v_line_cmp", 20'h400, vt.line_compare);
        @(negedge clk);
        vert_low[0] = 8'h5A;
        wr(8'h5E, 8'h10);
        chk("v_total_lo", 20'h05A, vt.vert_total);
        chk("v_retrace", 20'h400, vt.vert_retrace_start);
        chk("v_blank", 20'h000, vt.vert_blank_start);
    endtask : t_overflow

    task automatic t_engine();
        for (int i = 0; i < 3; i++) begin
            wr(8'h61, 8'(i << 5));
            chk("swap", 20'(i), {18'h0, swap});
        end
        wr(8'h66, 8'h03);
        chk("eng_pulse", 20'h1, {19'h0, eng_rst});
        chk("enhanced", 20'h1, {19'h0, enh_en});
        @(negedge clk);
        chk("eng_end", 20'h0, {19'h0, eng_rst});
        wr(8'h66, 8'h00);
        chk("eng_zero", 20'h0, {19'h0, eng_rst});
        chk("legacy", 20'h0, {19'h0, enh_en});
        wr(8'h66, 8'h88);
        bus(8'h51, 2'b00, 1'b1);
        bus(8'h52, 2'b00, 1'b0);
        bus(8'h55, 2'b00, 1'b1);
        bus(8'h48, 2'b00, 1'b1);
        bus(8'h4A, 2'b00, 1'b0);
        wr(8'h66, 8'h08);
        bus(8'h48, 2'b00, 1'b0);
        wr(8'h66, 8'h80);
        bus(8'hC2, 2'b01, 1'b1);
        bus(8'hC2, 2'b00, 1'b0);
        bus(8'h82, 2'b00, 1'b1);
        wr(8'h66, 8'h40);
        bus(8'hC2, 2'b10, 1'b0);
        chk("pa_float", 20'h0, {19'h0, pa_oe});
        wr(8'h66, 8'h00);
        chk("pa_drive", 20'h1, {19'h0, pa_oe});
        chk("pa_bus", 20'h0C3A5, {4'h0, pa_bus});
    endtask : t_engine

    task automatic t_modes();
        for (int p = 0; p < 2; p++) begin
            wr(8'h67, 8'(p));
            dot_clock = 1'b1;
            #1 chk("video_out_clock_hi", 20'(p), {19'h0, video_out_clock});
            dot_clock = 1'b0;
            #1 chk("video_out_clock_lo", 20'(1 - p), {19'h0, video_out_clock});
        end
        for (int i = 0; i < 4; i++) begin
            wr(8'h67, 8'(i << 2));
            chk("overlay", 20'(i), {18'h0, ovl});
        end
        for (int i = 0; i < 6; i++) begin
            wr(8'h67, {col_code[i], 4'h0});
            chk("colour", 20'(i), {17'h0, col});
        end
    endtask : t_modes

    task automatic t_strap_pages();
        rchk("locked", 8'h68, 8'h00);
        wr(8'h68, 8'hFF);
        lock = 8'hA5;
        rchk("strap", 8'h68, 8'h0C);
        chk("row_low", 20'h7, mt.row_low_half);
        chk("row_pcg", 20'h5, mt.row_pcg_half);
        wr(8'h68, 8'h03);
        rchk("strap_wr", 8'h68, 8'h03);
        chk("col_adj", 20'h3, mt.col_strobe_adjust);
        chk("row_low9", 20'h9, mt.row_low_half);
        chk("row_pcg7", 20'h7, mt.row_pcg_half);
        wr(8'h69, 8'h03);
        chk("dstart", 20'h31234, dstart);
        banking = 1'b1;
        wr(8'h6A, 8'h2A);
        chk("cpu_page", 20'h2A, cpu_page);
        wr(8'h6A, 8'h00);
        chk("cpu_old", 20'h15, cpu_page);
        linear_en = 1'b1;
        win64 = 1'b1;
        wr(8'h6A, 8'h00);
        chk("cpu_lin", 20'h00, cpu_page);
        banking = 1'b0;
        #1 chk("cpu_nobank", 20'h15, cpu_page);
    endtask : t_strap_pages

    task automatic t_blank(input int n);
        wr(8'h65, 8'(n << 3));
        blank_in_b = 1'b1;
        dot_clock = 1'b0;
        for (int i = -40; i < 4 * n + 6; i++) begin
            @(negedge clk);
            if (n > 0 && i == 4 * n - 4)
                chk("blank_held", 20'h1, {19'h0, blank_out_b});
            if (i == 4 * n + 1)
                chk("blank_low", 20'h0, {19'h0, blank_out_b});
            if (i == 0)
                blank_in_b = 1'b0;
            if (i % 2 != 0)
                dot_clock = ~dot_clock;
        end
    endtask : t_blank

    task automatic wrap_up();
        if (bad_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    // ==========================================================
    // Clock and main sequence
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        {rst_b, banking, linear_en, win64, dot_clock} = '0;
        {bus_write, bus_read, cmd_full, lp_full, burst, in_range} = '0;
        {cmd_empty, blank_in_b} = 2'b11;
        port_in = '0;
        strap = 8'h0C;
        lock = 8'h00;
        horiz_low = '{default: 8'h00};
        vert_low = '{default: 8'h00};
        old_start = 16'h1234;
        old_cpu = 6'h15;
        pa_in = 16'hC3A5;
        burst_low = 2'b00;
        bad_count = 0;
        n_compared = 0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        t_reset_masks();
        t_overflow();
        t_engine();
        t_modes();
        t_strap_pages();
        t_blank(0);
        t_blank(3);
        t_blank(7);
        wrap_up();
    end
endmodule : ext_display_ctrl_tb
`default_nettype wire
